// ===== common/ercr_pkg.sv
// Constants for the port receive checker and responder
// Summary of operation
// R1 - Pause frame holds transmitter off for its period when enabled.
// R2 - Enabled ping answering replies to each echo request from port addresses.
// R3 - Enabled solicitation answering sends an advertisement per solicitation.
// R4 - Enabled ARP answering replies to each ARP request from port addresses.
// R5 - Ping test mode answers all three kinds regardless of enables.
// R6 - Preamble and gap checks only at 10 Gbps or slower.
// R7 - Preamble unequal to expected (default 8, 3..15) is a violation.
// R8 - Ignore-preamble option suppresses preamble violations.
// R9 - Gap below minimum (default 12, 8..15) is a violation.
// R10 - Gigabit only: filter hides clock-adjust gap violations.
// R11 - Frames over 1518 up to jumbo limit are jumbo, not oversized.
// R12 - Remote fault only when enabled, electrical or SFP, autonegotiating.
// R13 - FEC degrade only at 200 or 400 Gbps, when enabled.
// R14 - Symbol errors summed per interval of set codewords, judged per interval.
// R15 - Count above activate threshold enters degraded state.
// R16 - Count below deactivate threshold leaves degraded state.
// R17 - Remote degrade sent if enabled and degraded or local alarm.
// R18 - In-band control on one port only; refused otherwise.
// R19 - No in-band control in 10 Gbps WAN mode.
// R20 - In-band traffic is TCP over IPv4 over Ethernet, optional VLAN.
// R21 - Reset clears degraded state and interval counter.
// R22 - Violation and degrade flags are sticky, software cleared.
package ercr_pkg;
   // ---
   // Register byte addresses
   // ---
   localparam logic [7:0] ADDR_CTRL = 8'h00;
   localparam logic [7:0] ADDR_PORT = 8'h04;
   localparam logic [7:0] ADDR_RXCFG = 8'h08;
   localparam logic [7:0] ADDR_JUMBO = 8'h0C;
   localparam logic [7:0] ADDR_FEC_INTERVAL = 8'h10;
   localparam logic [7:0] ADDR_FEC_ACT = 8'h14;
   localparam logic [7:0] ADDR_FEC_DEACT = 8'h18;
   localparam logic [7:0] ADDR_MAC_LO = 8'h1C;
   localparam logic [7:0] ADDR_MAC_HI = 8'h20;
   localparam logic [7:0] ADDR_IP = 8'h24;
   localparam logic [7:0] ADDR_STATUS = 8'h28;
   localparam logic [7:0] ADDR_FEC_LAST = 8'h2C;
   // ---
   // Control bit positions
   // ---
   localparam int CTRL_PAUSE = 0;
   localparam int CTRL_PING = 1;
   localparam int CTRL_NS = 2;
   localparam int CTRL_ARP = 3;
   localparam int CTRL_PING_TEST = 4;
   localparam int CTRL_IGN_PRE = 5;
   localparam int CTRL_IFG_FILT = 6;
   localparam int CTRL_RF = 7;
   localparam int CTRL_FEC = 8;
   localparam int CTRL_RD = 9;
   localparam int CTRL_INBAND = 10;
   localparam int CTRL_W = 11;
   // ---
   // Port field layout and encodings
   // ---
   localparam int PORT_RATE_LSB = 0;
   localparam int PORT_IF_LSB = 4;
   localparam int PORT_AUTONEG = 6;
   localparam int PORT_WAN = 7;
   localparam logic [2:0] RATE_1G = 3'h2;
   localparam logic [2:0] RATE_10G = 3'h3;
   localparam logic [2:0] RATE_200G = 3'h6;
   localparam logic [2:0] RATE_400G = 3'h7;
   localparam logic [1:0] IF_ELECTRICAL = 2'h0;
   localparam logic [1:0] IF_SFP = 2'h1;
   // ---
   // Receive check limits and defaults
   // ---
   localparam int RXCFG_IFG_LSB = 8;
   localparam logic [3:0] PRE_DEFAULT = 4'h8;
   localparam logic [3:0] PRE_MIN = 4'h3;
   localparam logic [3:0] IFG_DEFAULT = 4'hC;
   localparam logic [3:0] IFG_MIN = 4'h8;
   localparam logic [13:0] FRAME_STD_MAX = 14'h05EE;
   localparam logic [13:0] JUMBO_DEFAULT = 14'h233A;
   localparam logic [13:0] JUMBO_MIN = 14'h05EF;
   localparam logic [13:0] JUMBO_MAX = 14'h3E80;
   // ---
   // FEC degrade defaults
   // ---
   localparam logic [23:0] FEC_INTERVAL_DEFAULT = 24'h002000;
   localparam logic [23:0] FEC_ACT_DEFAULT = 24'h000400;
   localparam logic [23:0] FEC_DEACT_DEFAULT = 24'h000100;
   localparam logic [23:0] FEC_ACC_MAX = 24'hFFFFFF;
   // ---
   // Status bits, request kinds, pause scaling
   // ---
   localparam int ST_PRE = 0;
   localparam int ST_IFG = 1;
   localparam int ST_OVERSIZE = 2;
   localparam int ST_DEGRADE = 3;
   localparam int ST_STICKY_W = 4;
   localparam int ST_DEGRADED_LIVE = 8;
   localparam int ST_RF_LIVE = 9;
   localparam int ST_PAUSE_LIVE = 10;
   localparam int ST_INBAND_LIVE = 11;
   localparam logic [1:0] REQ_PING = 2'h0;
   localparam logic [1:0] REQ_NS = 2'h1;
   localparam logic [1:0] REQ_ARP = 2'h2;
   localparam int PAUSE_QUANTUM_SHIFT = 3;
   localparam logic [1:0] RESP_OKAY = 2'h0;
   localparam logic [1:0] RESP_SLVERR = 2'h2;
endpackage : ercr_pkg

// ===== logic/ercr_top.sv
// Receive checker and request responder for one Ethernet test port
`timescale 1ns/1ns
`default_nettype none
module ercr_top
   import ercr_pkg::*;
(
   input wire logic sys_clk,
   input wire logic resetn,
   // AXI4-Lite slave
   input wire logic [7:0] s_axi_awaddr,
   input wire logic s_axi_awvalid,
   output logic s_axi_awready,
   input wire logic [31:0] s_axi_wdata,
   input wire logic [3:0] s_axi_wstrb,
   input wire logic s_axi_wvalid,
   output logic s_axi_wready,
   output logic [1:0] s_axi_bresp,
   output logic s_axi_bvalid,
   input wire logic s_axi_bready,
   input wire logic [7:0] s_axi_araddr,
   input wire logic s_axi_arvalid,
   output logic s_axi_arready,
   output logic [31:0] s_axi_rdata,
   output logic [1:0] s_axi_rresp,
   output logic s_axi_rvalid,
   input wire logic s_axi_rready,
   // Receive parser events
   input wire logic rx_pause_valid,
   input wire logic [15:0] rx_pause_quanta,
   input wire logic rx_req_valid,
   input wire logic [1:0] rx_req_kind,
   input wire logic rx_preamble_valid,
   input wire logic [3:0] rx_preamble_len,
   input wire logic rx_gap_valid,
   input wire logic [3:0] rx_gap_len,
   input wire logic rx_gap_clk_adjust,
   input wire logic rx_frame_valid,
   input wire logic [13:0] rx_frame_len,
   input wire logic rx_class_valid,
   input wire logic rx_class_ipv4,
   input wire logic rx_class_tcp,
   input wire logic [1:0] rx_class_vlan_depth,
   input wire logic link_remote_fault,
   input wire logic fec_cw_valid,
   input wire logic [7:0] fec_cw_sym_err,
   input wire logic local_degrade_alarm,
   input wire logic other_port_inband,
   // Outputs
   output logic tx_pause_hold,
   output logic reply_valid,
   output logic [1:0] reply_kind,
   output logic [47:0] reply_src_mac,
   output logic [31:0] reply_src_ip,
   output logic rx_jumbo,
   output logic remote_fault_status,
   output logic remote_degrade_tx,
   output logic inband_claim,
   output logic inband_frame
);
   // ---
   // Registers
   // ---
   logic [CTRL_W-1:0] ctrl_reg;
   logic [7:0] port_reg;
   logic [3:0] pre_exp_reg;
   logic [3:0] ifg_min_reg;
   logic [13:0] jumbo_reg;
   logic [23:0] fec_interval_reg;
   logic [23:0] fec_act_reg;
   logic [23:0] fec_deact_reg;
   logic [23:0] fec_last_reg;
   logic [ST_STICKY_W-1:0] sticky_reg;
   logic [7:0] aw_addr_reg;
   logic aw_have_reg;
   logic [31:0] w_data_reg;
   logic [3:0] w_strb_reg;
   logic w_have_reg;
   logic [31:0] pause_cnt_reg;
   logic [23:0] fec_acc_reg;
   logic [23:0] fec_cw_cnt_reg;
   logic degraded_reg;

   logic [2:0] rate;
   logic rate_low;
   logic fec_on;
   logic inband_on;
   logic wr_fire;
   logic wr_hit;
   logic [31:0] wr_val;
   logic [31:0] wr_old;
   logic [31:0] rd_val;
   logic rd_hit;
   logic [ST_STICKY_W-1:0] sticky_set;
   logic [ST_STICKY_W-1:0] sticky_clr;
   logic pre_viol;
   logic ifg_viol;
   logic oversize;
   logic [24:0] fec_sum;
   logic [23:0] fec_acc_next;
   logic fec_end;

   // Merge a word under byte strobes
   function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw,
                                         input logic [3:0] strb);
      logic [31:0] r;
      r = old;
      for (int i = 0; i < 4; i++) begin
         if (strb[i]) begin
            r[i*8 +: 8] = nw[i*8 +: 8];
         end
      end
      return r;
   endfunction : merge

   assign rate = port_reg[PORT_RATE_LSB +: 3];
   assign rate_low = (rate <= RATE_10G); // see R6
   assign fec_on = ctrl_reg[CTRL_FEC] && (rate == RATE_200G || rate == RATE_400G); // see R13
   assign inband_on = ctrl_reg[CTRL_INBAND] && !port_reg[PORT_WAN]; // see R19

   // ---
   // AXI4-Lite write path
   // ---
   assign wr_fire = aw_have_reg && w_have_reg && !s_axi_bvalid;

   always_ff @(posedge sys_clk) begin
      if (!resetn) begin
         aw_have_reg <= 1'b0;
         aw_addr_reg <= 8'h00;
         s_axi_awready <= 1'b0;
      end else if (s_axi_awvalid && s_axi_awready) begin
         aw_have_reg <= 1'b1;
         aw_addr_reg <= s_axi_awaddr;
         s_axi_awready <= 1'b0;
      end else if (wr_fire) begin
         aw_have_reg <= 1'b0;
      end else begin
         s_axi_awready <= !aw_have_reg && !s_axi_bvalid;
      end
   end

   always_ff @(posedge sys_clk) begin
      if (!resetn) begin
         w_have_reg <= 1'b0;
         w_data_reg <= 32'h00000000;
         w_strb_reg <= 4'h0;
         s_axi_wready <= 1'b0;
      end else if (s_axi_wvalid && s_axi_wready) begin
         w_have_reg <= 1'b1;
         w_data_reg <= s_axi_wdata;
         w_strb_reg <= s_axi_wstrb;
         s_axi_wready <= 1'b0;
      end else if (wr_fire) begin
         w_have_reg <= 1'b0;
      end else begin
         s_axi_wready <= !w_have_reg && !s_axi_bvalid;
      end
   end

   always_comb begin
      wr_hit = 1'b1;
      wr_old = 32'h00000000;
      unique case (aw_addr_reg)
         ADDR_CTRL: wr_old = 32'({ctrl_reg});
         ADDR_PORT: wr_old = 32'({port_reg});
         ADDR_RXCFG: wr_old = 32'({ifg_min_reg, 4'h0, pre_exp_reg});
         ADDR_JUMBO: wr_old = 32'({jumbo_reg});
         ADDR_FEC_INTERVAL: wr_old = 32'({fec_interval_reg});
         ADDR_FEC_ACT: wr_old = 32'({fec_act_reg});
         ADDR_FEC_DEACT: wr_old = 32'({fec_deact_reg});
         ADDR_MAC_LO: wr_old = reply_src_mac[31:0];
         ADDR_MAC_HI: wr_old = 32'({reply_src_mac[47:32]});
         ADDR_IP: wr_old = reply_src_ip;
         ADDR_STATUS, ADDR_FEC_LAST: ;
         default: wr_hit = 1'b0;
      endcase
      wr_val = merge(wr_old, w_data_reg, w_strb_reg);
   end

   always_ff @(posedge sys_clk) begin
      if (!resetn) begin
         s_axi_bvalid <= 1'b0;
         s_axi_bresp <= RESP_OKAY;
      end else if (wr_fire) begin
         s_axi_bvalid <= 1'b1;
         s_axi_bresp <= wr_hit ? RESP_OKAY : RESP_SLVERR;
      end else if (s_axi_bready) begin
         s_axi_bvalid <= 1'b0;
      end
   end

   // ---
   // Configuration registers
   // ---
   always_ff @(posedge sys_clk) begin
      if (!resetn) begin
         ctrl_reg <= '0;
         port_reg <= 8'h00;
         pre_exp_reg <= PRE_DEFAULT;
         ifg_min_reg <= IFG_DEFAULT;
         jumbo_reg <= JUMBO_DEFAULT;
         fec_interval_reg <= FEC_INTERVAL_DEFAULT;
         fec_act_reg <= FEC_ACT_DEFAULT;
         fec_deact_reg <= FEC_DEACT_DEFAULT;
         reply_src_mac <= 48'h000000000000;
         reply_src_ip <= 32'h00000000;
      end else if (wr_fire) begin
         unique case (aw_addr_reg)
            ADDR_CTRL: begin
               ctrl_reg <= wr_val[CTRL_W-1:0];
               // Second port may not claim in-band control
               if (other_port_inband) begin
                  ctrl_reg[CTRL_INBAND] <= 1'b0; // see R18
               end
            end
            ADDR_PORT: port_reg <= wr_val[7:0];
            ADDR_RXCFG: begin
               // Out of range values leave the field unchanged
               if (wr_val[3:0] >= PRE_MIN) begin
                  pre_exp_reg <= wr_val[3:0]; // see R7
               end
               if (wr_val[RXCFG_IFG_LSB +: 4] >= IFG_MIN) begin
                  ifg_min_reg <= wr_val[RXCFG_IFG_LSB +: 4]; // see R9
               end
            end
            ADDR_JUMBO: begin
               if (wr_val[13:0] >= JUMBO_MIN && wr_val[13:0] <= JUMBO_MAX) begin
                  jumbo_reg <= wr_val[13:0]; // see R11
               end
            end
            ADDR_FEC_INTERVAL: begin
               if (wr_val[23:0] != 24'h000000) begin
                  fec_interval_reg <= wr_val[23:0];
               end
            end
            ADDR_FEC_ACT: fec_act_reg <= wr_val[23:0];
            ADDR_FEC_DEACT: fec_deact_reg <= wr_val[23:0];
            ADDR_MAC_LO: reply_src_mac[31:0] <= wr_val;
            ADDR_MAC_HI: reply_src_mac[47:32] <= wr_val[15:0];
            ADDR_IP: reply_src_ip <= wr_val;
            default: ;
         endcase
      end
   end

   // ---
   // Read path
   // ---
   always_comb begin
      rd_hit = 1'b1;
      rd_val = 32'h00000000;
      unique case (s_axi_araddr)
         ADDR_CTRL: rd_val = 32'({ctrl_reg});
         ADDR_PORT: rd_val = 32'({port_reg});
         ADDR_RXCFG: rd_val = 32'({ifg_min_reg, 4'h0, pre_exp_reg});
         ADDR_JUMBO: rd_val = 32'({jumbo_reg});
         ADDR_FEC_INTERVAL: rd_val = 32'({fec_interval_reg});
         ADDR_FEC_ACT: rd_val = 32'({fec_act_reg});
         ADDR_FEC_DEACT: rd_val = 32'({fec_deact_reg});
         ADDR_MAC_LO: rd_val = reply_src_mac[31:0];
         ADDR_MAC_HI: rd_val = 32'({reply_src_mac[47:32]});
         ADDR_IP: rd_val = reply_src_ip;
         ADDR_STATUS: begin
            rd_val[ST_STICKY_W-1:0] = sticky_reg;
            rd_val[ST_DEGRADED_LIVE] = degraded_reg;
            rd_val[ST_RF_LIVE] = remote_fault_status;
            rd_val[ST_PAUSE_LIVE] = tx_pause_hold;
            rd_val[ST_INBAND_LIVE] = inband_claim;
         end
         ADDR_FEC_LAST: rd_val = 32'({fec_last_reg});
         default: rd_hit = 1'b0;
      endcase
   end

   always_ff @(posedge sys_clk) begin
      if (!resetn) begin
         s_axi_arready <= 1'b0;
         s_axi_rvalid <= 1'b0;
         s_axi_rdata <= 32'h00000000;
         s_axi_rresp <= RESP_OKAY;
      end else if (s_axi_arvalid && s_axi_arready) begin
         s_axi_arready <= 1'b0;
         s_axi_rvalid <= 1'b1;
         s_axi_rdata <= rd_val;
         s_axi_rresp <= rd_hit ? RESP_OKAY : RESP_SLVERR;
      end else if (s_axi_rvalid) begin
         if (s_axi_rready) begin
            s_axi_rvalid <= 1'b0;
         end
      end else begin
         s_axi_arready <= 1'b1;
      end
   end

   // ---
   // Pause hold-off
   // ---
   always_ff @(posedge sys_clk) begin
      if (!resetn) begin
         pause_cnt_reg <= 32'h00000000;
         tx_pause_hold <= 1'b0;
      end else if (rx_pause_valid && ctrl_reg[CTRL_PAUSE]) begin
         // New frame restarts the period; zero quanta releases at once
         pause_cnt_reg <= 32'({rx_pause_quanta}) << PAUSE_QUANTUM_SHIFT; // see R1
         tx_pause_hold <= (rx_pause_quanta != 16'h0000); // see R1
      end else if (pause_cnt_reg != 32'h00000000) begin
         pause_cnt_reg <= pause_cnt_reg - 32'h00000001;
         tx_pause_hold <= (pause_cnt_reg != 32'h00000001);
      end else begin
         tx_pause_hold <= 1'b0;
      end
   end

   // ---
   // Request replies
   // ---
   always_ff @(posedge sys_clk) begin
      if (!resetn) begin
         reply_valid <= 1'b0;
         reply_kind <= REQ_PING;
      end else begin
         reply_kind <= rx_req_kind;
         reply_valid <= 1'b0;
         if (rx_req_valid) begin
            unique case (rx_req_kind)
               REQ_PING: reply_valid <= ctrl_reg[CTRL_PING] || ctrl_reg[CTRL_PING_TEST]; // see R2, R5
               REQ_NS: reply_valid <= ctrl_reg[CTRL_NS] || ctrl_reg[CTRL_PING_TEST]; // see R3, R5
               REQ_ARP: reply_valid <= ctrl_reg[CTRL_ARP] || ctrl_reg[CTRL_PING_TEST]; // see R4, R5
               default: reply_valid <= 1'b0;
            endcase
         end
      end
   end

   // ---
   // Receive checks and sticky status
   // ---
   assign pre_viol = rx_preamble_valid && rate_low && !ctrl_reg[CTRL_IGN_PRE] &&
                     (rx_preamble_len != pre_exp_reg); // see R6, R7, R8
   assign ifg_viol = rx_gap_valid && rate_low && (rx_gap_len < ifg_min_reg) &&
                     !(ctrl_reg[CTRL_IFG_FILT] && rate == RATE_1G && rx_gap_clk_adjust); // see R9, R10
   assign oversize = rx_frame_valid && (rx_frame_len > jumbo_reg); // see R11
   assign sticky_set = {fec_end && fec_on && (fec_acc_next > fec_act_reg), oversize, ifg_viol,
                        pre_viol};
   assign sticky_clr = (wr_fire && aw_addr_reg == ADDR_STATUS) ? wr_val[ST_STICKY_W-1:0] :
                       '0;

   // Set beats a clear landing in the same cycle
   always_ff @(posedge sys_clk) begin
      if (!resetn) begin
         sticky_reg <= '0;
      end else begin
         sticky_reg <= (sticky_reg & ~sticky_clr) | sticky_set; // see R22
      end
   end

   always_ff @(posedge sys_clk) begin
      if (!resetn) begin
         rx_jumbo <= 1'b0;
      end else begin
         rx_jumbo <= rx_frame_valid && (rx_frame_len > FRAME_STD_MAX) &&
                     (rx_frame_len <= jumbo_reg); // see R11
      end
   end

   // ---
   // Remote fault and in-band control
   // ---
   always_ff @(posedge sys_clk) begin
      if (!resetn) begin
         remote_fault_status <= 1'b0;
         inband_claim <= 1'b0;
         inband_frame <= 1'b0;
      end else begin
         remote_fault_status <= ctrl_reg[CTRL_RF] && port_reg[PORT_AUTONEG] &&
                                (port_reg[PORT_IF_LSB +: 2] == IF_ELECTRICAL ||
                                 port_reg[PORT_IF_LSB +: 2] == IF_SFP) &&
                                link_remote_fault; // see R12
         inband_claim <= inband_on; // see R18
         // Only plain or single-tagged IPv4 TCP counts as control traffic
         inband_frame <= inband_on && rx_class_valid && rx_class_ipv4 && rx_class_tcp &&
                         (rx_class_vlan_depth <= 2'h1); // see R19, R20
      end
   end

   // ---
   // FEC degrade judgement
   // ---
   assign fec_sum = {1'b0, fec_acc_reg} + 25'({fec_cw_sym_err});
   // Saturates so a burst cannot wrap to a low count
   assign fec_acc_next = fec_sum[24] ? FEC_ACC_MAX : fec_sum[23:0];
   assign fec_end = fec_cw_valid && (fec_cw_cnt_reg >= fec_interval_reg - 24'h000001);

   always_ff @(posedge sys_clk) begin
      if (!resetn || !fec_on) begin
         fec_acc_reg <= 24'h000000; // see R21
         fec_cw_cnt_reg <= 24'h000000; // see R21
         degraded_reg <= 1'b0; // see R21, R13
         fec_last_reg <= 24'h000000;
      end else if (fec_cw_valid) begin
         if (fec_end) begin
            fec_acc_reg <= 24'h000000; // see R14
            fec_cw_cnt_reg <= 24'h000000;
            fec_last_reg <= fec_acc_next;
            if (fec_acc_next > fec_act_reg) begin
               degraded_reg <= 1'b1; // see R15
            end else if (fec_acc_next < fec_deact_reg) begin
               degraded_reg <= 1'b0; // see R16
            end
         end else begin
            fec_acc_reg <= fec_acc_next; // see R14
            fec_cw_cnt_reg <= fec_cw_cnt_reg + 24'h000001;
         end
      end
   end

   always_ff @(posedge sys_clk) begin
      if (!resetn) begin
         remote_degrade_tx <= 1'b0;
      end else begin
         remote_degrade_tx <= ctrl_reg[CTRL_RD] && (degraded_reg || local_degrade_alarm); // see R17
      end
   end
endmodule : ercr_top
`default_nettype wire

// ===== sim/ercr_properties.sv
// Port checker for the receive checker and responder
`timescale 1ns/1ns
`default_nettype none
module ercr_properties
   import ercr_pkg::*;
(
   input wire logic sys_clk,
   input wire logic resetn,
   input wire logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready,
   input wire logic s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready, s_axi_rvalid,
   input wire logic [1:0] s_axi_bresp, rx_req_kind, reply_kind,
   input wire logic rx_pause_valid, tx_pause_hold, rx_req_valid, reply_valid,
   input wire logic rx_frame_valid, rx_jumbo, link_remote_fault, remote_fault_status,
   input wire logic [13:0] rx_frame_len
);
   default clocking cb @(posedge sys_clk); endclocking
   default disable iff (!resetn);
   sequence s_wr; s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready; endsequence
   sequence s_rd; s_axi_arvalid && s_axi_arready; endsequence
   property p_wr; s_wr |-> ##[1:2] s_axi_bvalid; endproperty
   a_wr: assert property (p_wr) else $error("write answer late");
   property p_bhold;
      s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp);
   endproperty
   a_bhold: assert property (p_bhold) else $error("write answer dropped");
   property p_rd; s_rd |=> s_axi_rvalid && !s_axi_arready ##1 !s_axi_arready; endproperty
   a_rd: assert property (p_rd) else $error("read answer late");
   property p_pause; $rose(tx_pause_hold) |-> $past(rx_pause_valid); endproperty
   a_pause: assert property (p_pause) else $error("hold without pause");
   property p_reply;
      reply_valid |-> $past(rx_req_valid) && reply_kind == $past(rx_req_kind) && reply_kind != 2'h3;
   endproperty
   a_reply: assert property (p_reply) else $error("reply without request");
   property p_rpulse; reply_valid && !rx_req_valid |=> !reply_valid; endproperty
   a_rpulse: assert property (p_rpulse) else $error("reply repeated");
   property p_jumbo;
      rx_jumbo |-> $past(rx_frame_valid) && $past(rx_frame_len) > FRAME_STD_MAX;
   endproperty
   a_jumbo: assert property (p_jumbo) else $error("jumbo for short frame");
   property p_rf; remote_fault_status |-> $past(link_remote_fault); endproperty
   a_rf: assert property (p_rf) else $error("fault without cause");
endmodule : ercr_properties
bind ercr_top ercr_properties i_props (.*);
`default_nettype wire

// ===== sim/ercr_link_model.sv
// Link partner model sending received-frame events into the port
`timescale 1ns/1ns
`default_nettype none
module ercr_link_model (
   input wire logic sys_clk,
   output logic rx_pause_valid, rx_req_valid, rx_preamble_valid, rx_frame_valid,
   output logic fec_cw_valid, rx_gap_valid, rx_class_valid, rx_class_ipv4, rx_class_tcp,
   output logic rx_gap_clk_adjust, link_remote_fault, local_degrade_alarm,
   output logic [15:0] rx_pause_quanta,
   output logic [1:0] rx_req_kind, rx_class_vlan_depth,
   output logic [3:0] rx_preamble_len, rx_gap_len,
   output logic [13:0] rx_frame_len,
   output logic [7:0] fec_cw_sym_err
);
   logic [6:0] vld = '0;
   logic [15:0] fld = '0;
   logic [2:0] lvl = '0;
   assign {rx_class_valid, rx_gap_valid, fec_cw_valid, rx_frame_valid} = vld[6:3];
   assign {rx_preamble_valid, rx_req_valid, rx_pause_valid} = vld[2:0];
   assign {local_degrade_alarm, link_remote_fault, rx_gap_clk_adjust} = lvl;
   assign rx_pause_quanta = fld;
   assign {rx_req_kind, rx_preamble_len, rx_gap_len} = {fld[1:0], fld[3:0], fld[3:0]};
   assign {rx_frame_len, fec_cw_sym_err} = {fld[13:0], fld[7:0]};
   assign {rx_class_vlan_depth, rx_class_tcp, rx_class_ipv4} = fld[3:0];
   // Fields invert after each event, so stale values never pass as live
   task automatic ev(input int k, input logic [15:0] v);
      @(posedge sys_clk);
      vld <= 7'(1 << k);
      fld <= v;
      @(posedge sys_clk);
      vld <= '0;
      fld <= ~v;
      #1;
   endtask : ev
endmodule : ercr_link_model
`default_nettype wire

// ===== sim/tb_top.sv
// Self-checking bench for the receive checker and responder
`timescale 1ns/1ns
`default_nettype none
module tb_top
   import ercr_pkg::*;
;
   logic sys_clk, resetn, s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid;
   logic s_axi_bready, s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready, other_port_inband;
   logic rx_pause_valid, rx_req_valid, rx_preamble_valid, rx_gap_valid, rx_gap_clk_adjust;
   logic rx_frame_valid, rx_class_valid, rx_class_ipv4, rx_class_tcp, link_remote_fault;
   logic fec_cw_valid, local_degrade_alarm, tx_pause_hold, reply_valid, rx_jumbo;
   logic remote_fault_status, remote_degrade_tx, inband_claim, inband_frame;
   logic [1:0] s_axi_bresp, s_axi_rresp, rx_req_kind, rx_class_vlan_depth, reply_kind;
   logic [3:0] s_axi_wstrb, rx_preamble_len, rx_gap_len;
   logic [7:0] s_axi_awaddr, s_axi_araddr, fec_cw_sym_err;
   logic [13:0] rx_frame_len;
   logic [15:0] rx_pause_quanta;
   logic [31:0] s_axi_wdata, s_axi_rdata, reply_src_ip;
   logic [47:0] reply_src_mac;
   int miscompares = 0;
   int checks_done = 0;
   ercr_top i_dut (.*);
   ercr_link_model i_link (.*);
   initial begin
      sys_clk = 1'b0;
      forever #10 sys_clk = ~sys_clk;
   end
   task automatic chk(input string s, input logic [31:0] e, input logic [31:0] g);
      checks_done++;
      if (g !== e) begin
         miscompares++;
         $display("BAD %s exp %h got %h", s, e, g);
      end
   endtask : chk
   task automatic print_verdict;
      $display("checks %0d mismatches %0d", checks_done, miscompares);
      if (miscompares == 0 && checks_done > 0) $display("bench passed");
      else $display("bench failed");
      $finish;
   endtask : print_verdict
   task automatic tick(input int c);
      repeat (c) @(posedge sys_clk);
      #1;
   endtask : tick
   // One bus access; a lost answer counts as a mismatch and ends the run
   task automatic ax(input logic w, input logic [7:0] a, input logic [31:0] d, input logic [1:0] r);
      int n = 0;
      logic [1:0] p;
      p = {w, w};
      @(posedge sys_clk);
      s_axi_awaddr <= a;
      s_axi_araddr <= a;
      s_axi_wdata <= d;
      s_axi_awvalid <= w;
      s_axi_wvalid <= w;
      s_axi_bready <= w;
      s_axi_arvalid <= !w;
      s_axi_rready <= !w;
      while (n < 50 && !(w ? s_axi_bvalid && p == 2'h0 : s_axi_rvalid)) begin
         @(posedge sys_clk);
         n++;
         if (s_axi_awready) p[1] = 1'b0;
         if (s_axi_wready) p[0] = 1'b0;
         if (s_axi_arready) s_axi_arvalid <= 1'b0;
         s_axi_awvalid <= p[1];
         s_axi_wvalid <= p[0];
      end
      s_axi_bready <= 1'b0;
      s_axi_rready <= 1'b0;
      if (n >= 50) begin
         miscompares++;
         print_verdict();
      end
      chk("resp", 32'(r), 32'(w ? s_axi_bresp : s_axi_rresp));
      if (!w) chk("rdata", d, s_axi_rdata);
   endtask : ax
   initial begin
      int n;
      resetn = 1'b0;
      other_port_inband = 1'b0;
      s_axi_wstrb = 4'hF;
      {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = 5'h00;
      {s_axi_awaddr, s_axi_araddr, s_axi_wdata} = 48'h0;
      repeat (10) @(posedge sys_clk);
      resetn <= 1'b1;
      ax(1'b0, ADDR_RXCFG, 32'h00000C08, RESP_OKAY);
      ax(1'b0, ADDR_JUMBO, 32'h0000233A, RESP_OKAY);
      ax(1'b0, ADDR_STATUS, 32'h0, RESP_OKAY);
      ax(1'b0, 8'h30, 32'h0, RESP_SLVERR);
      ax(1'b1, 8'h30, 32'h1, RESP_SLVERR);
      ax(1'b1, ADDR_IP, 32'hC0A80A05, RESP_OKAY);
      for (int i = 0; i < 4; i++) begin
         ax(1'b1, ADDR_CTRL, 32'h2 << i, RESP_OKAY);
         for (int k = 0; k < 3; k++) begin
            i_link.ev(1, 16'(k));
            chk("reply", (i == 3 || i == k) ? 32'(4 + k) : 32'h0,
               {29'h0, reply_valid, reply_kind & {2{reply_valid}}});
         end
      end
      chk("src_ip", 32'hC0A80A05, reply_src_ip);
      ax(1'b1, ADDR_CTRL, 32'h1, RESP_OKAY);
      i_link.ev(0, 16'h0002);
      n = 0;
      while (tx_pause_hold && n < 100) begin
         tick(1);
         n++;
      end
      chk("pause", 32'(2 << PAUSE_QUANTUM_SHIFT), 32'(n));
      i_link.ev(2, 16'h0007);
      i_link.ev(3, 16'h05EF);
      chk("jumbo", 32'h1, 32'(rx_jumbo));
      i_link.ev(3, 16'h233B);
      i_link.ev(5, 16'h000B);
      ax(1'b0, ADDR_STATUS, 32'h7, RESP_OKAY);
      ax(1'b1, ADDR_STATUS, 32'hF, RESP_OKAY);
      ax(1'b1, ADDR_CTRL, 32'h20, RESP_OKAY);
      i_link.ev(2, 16'h0007);
      ax(1'b1, ADDR_PORT, 32'h5, RESP_OKAY);
      i_link.ev(5, 16'h0008);
      ax(1'b0, ADDR_STATUS, 32'h0, RESP_OKAY);
      ax(1'b1, ADDR_PORT, 32'h6, RESP_OKAY);
      ax(1'b1, ADDR_FEC_INTERVAL, 32'h4, RESP_OKAY);
      ax(1'b1, ADDR_FEC_ACT, 32'h3, RESP_OKAY);
      ax(1'b1, ADDR_FEC_DEACT, 32'h1, RESP_OKAY);
      ax(1'b1, ADDR_CTRL, 32'h300, RESP_OKAY);
      for (int j = 0; j < 8; j++) begin
         i_link.ev(4, j < 4 ? 16'h1 : 16'h0);
         tick(1);
         chk("degrade", 32'(j >= 3 && j < 7), 32'(remote_degrade_tx));
      end
      ax(1'b0, ADDR_FEC_LAST, 32'h0, RESP_OKAY);
      i_link.lvl <= 3'h4;
      tick(3);
      chk("local", 32'h1, 32'(remote_degrade_tx));
      ax(1'b1, ADDR_PORT, 32'h40, RESP_OKAY);
      ax(1'b1, ADDR_CTRL, 32'h80, RESP_OKAY);
      i_link.lvl <= 3'h2;
      tick(3);
      chk("fault", 32'h1, 32'(remote_fault_status));
      ax(1'b1, ADDR_CTRL, 32'h400, RESP_OKAY);
      i_link.ev(6, 16'h0007);
      chk("inband", 32'h3, {30'h0, inband_claim, inband_frame});
      other_port_inband <= 1'b1;
      ax(1'b1, ADDR_CTRL, 32'h400, RESP_OKAY);
      ax(1'b0, ADDR_CTRL, 32'h0, RESP_OKAY);
      print_verdict();
   end
endmodule : tb_top
`default_nettype wire
